/* File: rtl/scsc_top.sv */
// The implementer's own choices: the strobed register port and the register addresses.
module scsc_top
  import scsc_pkg::*;
#(
  parameter int TICK_N = TICK_CYC
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic [31:0]           rdata_o,
  input  wire logic             ext_trig_i,
  input  wire logic             ext_adv_i,
  input  wire logic             meter_inst_i,
  input  wire logic             meas_valid_i,
  input  wire logic [CW-1:0]    meas_ch_i,
  input  wire logic [31:0]      meas_data_i,
  output logic                  meas_req_o,
  output logic [CW-1:0]         meas_ch_o,
  output logic [NCH-1:0]        relay_o,
  output logic                  reading_valid_o,
  output logic [CW-1:0]         reading_ch_o,
  output logic [63:0]           reading_o,
  output logic                  alarm_clr_o,
  output logic [CW-1:0]         alarm_ch_o,
  output logic [23:0]           disp_label_o
);
  scsc_scale_if sif ();
  scsc_st_type  st_q;
  scsc_adv_type adv_q;
  scsc_trg_type trg_q;
  logic         meter_q;
  logic [2:0]   trg_s_q, adv_s_q, inst_s_q;
  logic [NCH-1:0] list_q, fw_q, sreq_q, alrm_q;
  logic [7:0]   func_q [NCH];
  logic [63:0]  gain_q [NCH];
  logic [63:0]  offs_q [NCH];
  logic [23:0]  lbl_q  [NCH];
  logic [CW-1:0] sel_q, cur_q, null_ch_q;
  logic [31:0]  lo_q;
  logic [3:0]   err_q;
  logic         null_q;
  logic [15:0]  ival_q, tcnt_q;
  logic [$clog2(TICK_CYC+1)-1:0] div_q;
  logic         ms_tick;

  function automatic logic in_rng(input logic [63:0] v);
    logic [63:0] m;
    m = v[63] ? -v : v;
    return m <= VAL_MAX;
  endfunction

  function automatic logic is_let(input logic [7:0] c);
    return (c >= 8'h41 && c <= 8'h5A);
  endfunction

  function automatic logic lbl_ok(input logic [23:0] l);
    logic ok;
    ok = is_let(l[23:16]) || l[23:16] == CH_HASH;
    for (int i = 0; i < 2; i++) begin
      if (!(is_let(l[8*i +: 8]) || l[8*i +: 8] == CH_US ||
            (l[8*i +: 8] >= 8'h30 && l[8*i +: 8] <= 8'h39) ||
            l[8*i +: 8] == 8'h00)) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Mask of relays for a channel, with its pair when pairing applies.
  function automatic logic [NCH-1:0] ch_mask(input logic [CW-1:0] c,
                                             input logic [1:0] k,
                                             input logic pr);
    logic [NCH-1:0] m;
    logic [CW:0]    p;
    m = '0;
    m[c] = 1'b1;
    p = {1'b0, c} + {1'b0, (k == K_MUXB) ? PAIR_B : PAIR_A};
    if (pr && k <= K_MUXB && p < (CW+1)'(NCH)) begin
      m[p[CW-1:0]] = 1'b1;
    end
    return m;
  endfunction

  // Next listed channel at or after start; bit CW flags success.
  function automatic logic [CW:0] next_ch(input logic [NCH-1:0] l,
                                          input logic [CW:0] s);
    logic [CW:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (l[i] && (CW+1)'(i) >= s) begin
        r = {1'b1, CW'(i)};
      end
    end
    return r;
  endfunction

  // Asynchronous pins pass two flops; the third flop feeds edge detect.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      trg_s_q  <= '0;
      adv_s_q  <= '0;
      inst_s_q <= '0;
    end else begin
      trg_s_q  <= {trg_s_q[1:0], ext_trig_i};
      adv_s_q  <= {adv_s_q[1:0], ext_adv_i};
      inst_s_q <= {inst_s_q[1:0], meter_inst_i};
    end
  end

  wire w_ctrl = wr_i && addr_i == A_CTRL;
  wire w_cmd  = wr_i && addr_i == A_CMD;
  wire meter_off = !meter_q || !inst_s_q[1];
  wire frst  = w_ctrl && wdata_i[4] != meter_q;
  wire card  = w_cmd && wdata_i[C_CARD];
  wire [1:0] sk = func_q[sel_q][1:0];
  wire sel_dig = sk == K_DIG || sk == K_TOT;
  wire ext_tr = trg_s_q[1] && !trg_s_q[2];
  wire ext_ad = adv_s_q[1] && !adv_s_q[2];
  wire [1:0] cur_k = func_q[cur_q][1:0];
  wire cur_dig = cur_k == K_DIG || cur_k == K_TOT;

  // Scan trigger, from whichever source is selected.
  logic trig_ev, adv_ev;
  always_comb begin
    case (trg_q)
      TRG_BUS: trig_ev = w_cmd && wdata_i[C_TRIG];
      TRG_IMM: trig_ev = 1'b1;
      TRG_EXT: trig_ev = ext_tr;
      TRG_TIM: trig_ev = ms_tick && tcnt_q >= ival_q;
      default: trig_ev = 1'b0;
    endcase
    case (adv_q)
      ADV_EXT: adv_ev = ext_ad;
      ADV_BUS: adv_ev = w_cmd && wdata_i[C_ADV];
      ADV_IMM: adv_ev = 1'b1;
      default: adv_ev = 1'b0;
    endcase
  end

  // Source selection, meter state and the trigger conflict check.
  scsc_adv_type adv_n;
  scsc_trg_type trg_n;
  always_comb begin
    adv_n = meter_off ? scsc_adv_type'(wdata_i[1:0]) : adv_q;
    trg_n = scsc_trg_type'(wdata_i[3:2]);
  end
  wire conf = w_ctrl && !frst && ((adv_n == ADV_EXT && trg_n == TRG_EXT)
              || (adv_n == ADV_BUS && trg_n == TRG_BUS));
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || frst) begin
      adv_q <= ADV_EXT;
      trg_q <= TRG_TIM;
    end else if (w_ctrl) begin
      adv_q <= adv_n;
      trg_q <= conf ? TRG_IMM : trg_n;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meter_q <= 1'b0;
    end else if (w_ctrl) begin
      meter_q <= wdata_i[4];
    end
  end

  // Sticky errors; a new error in the clearing cycle survives.
  wire w_bad_gain = (wr_i && addr_i == A_GHI && !in_rng({wdata_i, lo_q}));
  wire w_bad_offs = (wr_i && addr_i == A_OHI && !in_rng({wdata_i, lo_q}));
  wire w_bad_lbl  = wr_i && addr_i == A_LBL && !lbl_ok(wdata_i[23:0]);
  wire w_en_sc    = wr_i && addr_i == A_SEN && wdata_i[0];
  wire w_ref = (w_en_sc && sel_dig) || (!meter_off &&
               ((w_ctrl && wdata_i[1:0] != adv_q) ||
                (wr_i && addr_i == A_FWIRE)));
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      err_q <= '0;
    end else begin
      err_q <= (err_q & ~((wr_i && addr_i == A_STAT) ? wdata_i[3:0] : 4'h0))
             | {w_ref, w_bad_lbl, w_bad_gain || w_bad_offs, conf};
    end
  end

  // Scan list, pairing bits, channel select, interval and alarm state.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || frst) begin
      list_q <= '0;
      fw_q   <= '0;
      sel_q  <= '0;
      alrm_q <= '0;
      ival_q <= IVAL_RST;
    end else begin
      if (wr_i && addr_i == A_LIST) list_q <= wdata_i[NCH-1:0];
      if (wr_i && addr_i == A_FWIRE && meter_off) begin
        fw_q <= wdata_i[NCH-1:0];
      end
      if (wr_i && addr_i == A_SEL) sel_q <= wdata_i[CW-1:0];
      if (wr_i && addr_i == A_IVAL) ival_q <= wdata_i[15:0];
      if (wr_i && addr_i == A_ALRM) alrm_q <= wdata_i[NCH-1:0];
      else if (w_en_sc && !sel_dig) alrm_q[sel_q] <= 1'b0;
    end
  end

  // Per-channel scaling store; card reset deliberately leaves it alone.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || frst) begin
      for (int i = 0; i < NCH; i++) begin
        gain_q[i] <= GAIN_RST;
        offs_q[i] <= OFFS_RST;
        lbl_q[i]  <= '0;
        func_q[i] <= '0;
      end
      sreq_q <= '0;
      lo_q   <= '0;
    end else begin
      if (wr_i && (addr_i == A_GLO || addr_i == A_OLO)) lo_q <= wdata_i;
      if (wr_i && addr_i == A_GHI && !w_bad_gain) begin
        gain_q[sel_q] <= {wdata_i, lo_q};
      end
      if (wr_i && addr_i == A_OHI && !w_bad_offs) begin
        offs_q[sel_q] <= {wdata_i, lo_q};
      end
      if (wr_i && addr_i == A_LBL && !w_bad_lbl) begin
        lbl_q[sel_q] <= wdata_i[23:0];
      end
      if (wr_i && addr_i == A_SEN && !(w_en_sc && sel_dig)) begin
        sreq_q[sel_q] <= wdata_i[0];
      end
      if (null_q && meas_valid_i && meas_ch_i == null_ch_q) begin
        offs_q[null_ch_q] <= 64'($signed(meas_data_i));
      end
      if (wr_i && addr_i == A_FUNC && wdata_i[7:0] != func_q[sel_q]) begin
        func_q[sel_q] <= wdata_i[7:0];
        sreq_q[sel_q] <= 1'b0;
        gain_q[sel_q] <= GAIN_RST;
        offs_q[sel_q] <= OFFS_RST;
      end
    end
  end

  // Null capture requests one reading and waits for that channel.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || frst) begin
      null_q     <= 1'b0;
      null_ch_q  <= '0;
      meas_req_o <= 1'b0;
    end else begin
      meas_req_o <= w_cmd && wdata_i[C_NULL] && !null_q;
      if (w_cmd && wdata_i[C_NULL] && !null_q) begin
        null_q    <= 1'b1;
        null_ch_q <= sel_q;
      end else if (meas_valid_i && meas_ch_i == null_ch_q) begin
        null_q <= 1'b0;
      end
    end
  end
  assign meas_ch_o = null_ch_q;

  // Millisecond divider and scan-to-scan interval counter.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      div_q   <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= div_q == ($bits(div_q))'(TICK_N - 1);
      div_q <= (div_q == ($bits(div_q))'(TICK_N - 1)) ? '0 : div_q + 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || st_q == ST_IDLE || (st_q == ST_ARMED && trig_ev)) begin
      tcnt_q <= '0;
    end else if (ms_tick && tcnt_q != 16'hFFFF) begin
      tcnt_q <= tcnt_q + 16'h0001;
    end
  end

  // Scan sequencer and relay drive.
  wire [CW:0] first = next_ch(list_q, '0);
  wire [CW:0] nxt   = next_ch(list_q, {1'b0, cur_q} + 1'b1);
  wire        pr    = list_q != '0;
  wire [NCH-1:0] cmask = ch_mask(cur_q, cur_k, fw_q[cur_q]);
  wire [CW-1:0] dch = wdata_i[CW-1:0];
  wire [NCH-1:0] dmask = ch_mask(dch, func_q[dch][1:0],
                                 pr && fw_q[dch]);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || frst || card) begin
      st_q    <= ST_IDLE;
      cur_q   <= '0;
      relay_o <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (w_cmd && wdata_i[C_INIT] && pr) st_q <= ST_ARMED;
        end
        ST_ARMED: begin
          if (trig_ev && first[CW]) begin
            st_q    <= ST_ACTIVE;
            cur_q   <= first[CW-1:0];
            relay_o <= relay_o | ch_mask(first[CW-1:0],
                       func_q[first[CW-1:0]][1:0], fw_q[first[CW-1:0]]);
          end
        end
        ST_ACTIVE: begin
          if (adv_ev || cur_dig) begin
            if (nxt[CW]) begin
              cur_q   <= nxt[CW-1:0];
              relay_o <= (relay_o & ~cmask) | ch_mask(nxt[CW-1:0],
                         func_q[nxt[CW-1:0]][1:0], fw_q[nxt[CW-1:0]]);
            end else begin
              st_q    <= ST_ARMED;
              relay_o <= relay_o & ~cmask;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (wr_i && addr_i == A_DIR) begin
        case (wdata_i[9:8])
          2'h1: relay_o <= relay_o | dmask;
          2'h2: relay_o <= relay_o & ~dmask;
          2'h3: relay_o <= dmask;
          default: relay_o <= relay_o;
        endcase
      end
    end
  end

  // Readings pass through the scaler with the channel's live enable.
  assign sif.valid = meas_valid_i;
  assign sif.ch    = meas_ch_i;
  assign sif.raw   = meas_data_i;
  assign sif.gain  = gain_q[meas_ch_i];
  assign sif.offs  = offs_q[meas_ch_i];
  assign sif.en    = sreq_q[meas_ch_i] && list_q[meas_ch_i];
  scsc_scaler u_scaler (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sif        (sif)
  );
  assign reading_valid_o = sif.rvalid;
  assign reading_ch_o    = sif.rch;
  assign reading_o       = sif.res;

  // Alarm clear pulse and the local display form of the label.
  wire [23:0] sl = lbl_q[sel_q];
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      alarm_clr_o  <= 1'b0;
      alarm_ch_o   <= '0;
      disp_label_o <= '0;
    end else begin
      alarm_clr_o  <= w_en_sc && !sel_dig;
      alarm_ch_o   <= sel_q;
      disp_label_o <= {(sl[23:16] == CH_HASH) ? CH_DEG : sl[23:16],
                       sl[15:0]};
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        A_CTRL:  rdata_o <= {26'h0, inst_s_q[1], meter_q, trg_q, adv_q};
        A_STAT:  rdata_o <= {15'h0, meter_q, 3'h0, cur_q, 2'h0, st_q,
                             err_q};
        A_LIST:  rdata_o <= 32'(list_q);
        A_FWIRE: rdata_o <= 32'(fw_q & list_q);
        A_SEL:   rdata_o <= 32'(sel_q);
        A_FUNC:  rdata_o <= 32'(func_q[sel_q]);
        A_GLO:   rdata_o <= gain_q[sel_q][31:0];
        A_GHI:   rdata_o <= gain_q[sel_q][63:32];
        A_OLO:   rdata_o <= offs_q[sel_q][31:0];
        A_OHI:   rdata_o <= offs_q[sel_q][63:32];
        A_LBL:   rdata_o <= {8'h00, (sl[23:16] == CH_HASH) ? CH_SPC
                             : sl[23:16], sl[15:0]};
        A_SEN:   rdata_o <= 32'(sreq_q[sel_q] && list_q[sel_q]);
        A_ALRM:  rdata_o <= 32'(alrm_q);
        A_IVAL:  rdata_o <= 32'(ival_q);
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  sequence s_adv_hit;
    st_q == ST_ACTIVE && adv_ev && nxt[CW];
  endsequence
  a_adv_step: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) s_adv_hit and (!frst && !card && !wr_i)
    |=> cur_q == $past(nxt[CW-1:0]) && !(|(relay_o & $past(cmask))))
    else $error("Advance did not move to the next listed channel.");
  a_idle_hold: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) st_q != ST_ACTIVE && !trig_ev && !wr_i
    |=> $stable(cur_q))
    else $error("Channel moved before the scan was triggered.");
  a_trig_conf: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) conf |=> trg_q == TRG_IMM && err_q[E_CONF])
    else $error("Source conflict not flagged or trigger not immediate.");
  a_cfg_guard: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) !meter_off && !frst |=> $stable(adv_q)
    && $stable(fw_q))
    else $error("Advance or pairing changed while the meter is on.");
  a_dig_auto: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) st_q == ST_ACTIVE && cur_dig && !frst && !card
    |=> cur_q != $past(cur_q) || st_q == ST_ARMED)
    else $error("Digital channel waited for an advance.");
  a_meter_rst: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) frst |=> adv_q == ADV_EXT && trg_q == TRG_TIM
    && sreq_q == '0 && list_q == '0)
    else $error("Meter change did not factory reset.");
  a_dig_refuse: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) w_en_sc && sel_dig && !frst
    |=> !sreq_q[$past(sel_q)] && err_q[E_REF])
    else $error("Scaling enabled on a digital channel.");
  a_cfg_clear: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) wr_i && addr_i == A_FUNC &&
    wdata_i[7:0] != func_q[sel_q] |=> gain_q[$past(sel_q)] == GAIN_RST
    && offs_q[$past(sel_q)] == OFFS_RST && !sreq_q[$past(sel_q)])
    else $error("Configuration change kept scaling values.");
  a_card_keep: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) card |=> $stable(sreq_q)
    && $stable(gain_q[sel_q]))
    else $error("Card reset disturbed scaling.");
  a_gain_rng: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) w_bad_gain && !frst |=> err_q[E_RNG]
    && $stable(gain_q[sel_q]))
    else $error("Out-of-range gain was accepted.");
endmodule

/* File: rtl/scsc_pkg.sv */
package scsc_pkg;
  localparam int NCH = 20;
  localparam int CW  = 5;
  localparam int AW  = 8;
  // Register byte offsets.
  localparam logic [AW-1:0] A_CTRL  = 8'h00;
  localparam logic [AW-1:0] A_CMD   = 8'h04;
  localparam logic [AW-1:0] A_STAT  = 8'h08;
  localparam logic [AW-1:0] A_LIST  = 8'h0C;
  localparam logic [AW-1:0] A_FWIRE = 8'h10;
  localparam logic [AW-1:0] A_SEL   = 8'h14;
  localparam logic [AW-1:0] A_FUNC  = 8'h18;
  localparam logic [AW-1:0] A_GLO   = 8'h1C;
  localparam logic [AW-1:0] A_GHI   = 8'h20;
  localparam logic [AW-1:0] A_OLO   = 8'h24;
  localparam logic [AW-1:0] A_OHI   = 8'h28;
  localparam logic [AW-1:0] A_LBL   = 8'h2C;
  localparam logic [AW-1:0] A_SEN   = 8'h30;
  localparam logic [AW-1:0] A_ALRM  = 8'h34;
  localparam logic [AW-1:0] A_IVAL  = 8'h38;
  localparam logic [AW-1:0] A_DIR   = 8'h3C;
  // Command bits in A_CMD.
  localparam int C_INIT = 0;
  localparam int C_TRIG = 1;
  localparam int C_ADV  = 2;
  localparam int C_CARD = 3;
  localparam int C_NULL = 4;
  // Status error bits.
  localparam int E_CONF = 0;
  localparam int E_RNG  = 1;
  localparam int E_LBL  = 2;
  localparam int E_REF  = 3;
  typedef enum logic [1:0] {
    ADV_EXT = 2'b00, ADV_BUS = 2'b01, ADV_IMM = 2'b10
  } scsc_adv_type;
  typedef enum logic [1:0] {
    TRG_BUS = 2'b00, TRG_IMM = 2'b01, TRG_EXT = 2'b10, TRG_TIM = 2'b11
  } scsc_trg_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_ACTIVE = 2'b10
  } scsc_st_type;
  // Channel kinds held in the low bits of the function register.
  localparam logic [1:0] K_MUXA = 2'h0;
  localparam logic [1:0] K_MUXB = 2'h1;
  localparam logic [1:0] K_DIG  = 2'h2;
  localparam logic [1:0] K_TOT  = 2'h3;
  localparam logic [CW-1:0] PAIR_A = 5'h0A;
  localparam logic [CW-1:0] PAIR_B = 5'h08;
  localparam logic [63:0] GAIN_RST = 64'h0000_0000_0000_0001;
  localparam logic [63:0] OFFS_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] VAL_MAX  = 64'h0003_8D7E_A4C6_8000;
  localparam logic [15:0] IVAL_RST = 16'h03E8;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DEG  = 8'hB0;
  localparam logic [7:0] CH_SPC  = 8'h20;
  localparam logic [7:0] CH_US   = 8'h5F;
  // Millisecond tick for the scan timer.
  localparam int TICK_US = 1000;
  localparam int CLK_MHZ = 10;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
endpackage

/* File: rtl/scsc_scale_if.sv */
interface scsc_scale_if;
  import scsc_pkg::*;
  logic              valid;
  logic [CW-1:0]     ch;
  logic [31:0]       raw;
  logic [63:0]       gain;
  logic [63:0]       offs;
  logic              en;
  logic              rvalid;
  logic [CW-1:0]     rch;
  logic [63:0]       res;
  modport eng (output valid, ch, raw, gain, offs, en,
               input rvalid, rch, res);
  modport alu (input valid, ch, raw, gain, offs, en,
               output rvalid, rch, res);
endinterface

/* File: rtl/scsc_scaler.sv */
module scsc_scaler
  import scsc_pkg::*;
(
  input  wire logic   core_clk_i,
  input  wire logic   rst_n_i,
  scsc_scale_if.alu   sif
);
  // One registered stage; a wide multiply wants its own pipeline slot.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sif.rvalid <= 1'b0;
      sif.rch    <= '0;
      sif.res    <= '0;
    end else begin
      sif.rvalid <= sif.valid;
      sif.rch    <= sif.ch;
      if (sif.valid) begin
        if (sif.en) begin
          sif.res <= 64'($signed(sif.gain) * $signed(sif.raw))
                     - sif.offs;
        end else begin
          sif.res <= 64'($signed(sif.raw));
        end
      end
    end
  end

  a_scale_math: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) sif.valid && sif.en |=> sif.rvalid &&
    sif.res == 64'($signed($past(sif.gain)) * $signed($past(sif.raw)))
    - $past(sif.offs))
    else $error("Scaled reading is not gain times raw minus offset.");
endmodule

/* File: dv/scsc_meter_model.sv */
// Behavioural stand-in for the external instrument on the scan link.
module scsc_meter_model
  import scsc_pkg::*;
#(
  parameter logic [31:0] NULL_RAW = 32'h0000_0007
) (
  input  wire logic          clk_i,
  input  wire logic          req_i,
  input  wire logic [CW-1:0] req_ch_i,
  output logic               adv_o,
  output logic               valid_o,
  output logic [CW-1:0]      ch_o,
  output logic [31:0]        data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    adv_o = 1'b0;
    valid_o = 1'b0;
    ch_o = '0;
    data_o = '0;
  end
  // The pulse is held long enough to pass the two-flop synchroniser.
  task automatic advance();
    adv_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    adv_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Data is scrambled after the strobe so a stale value never looks valid.
  task automatic measure(input logic [CW-1:0] c, input logic [31:0] raw);
    @(posedge clk_i);
    valid_o <= 1'b1;
    ch_o <= c;
    data_o <= raw;
    @(posedge clk_i);
    valid_o <= 1'b0;
    data_o <= ~raw;
  endtask
  // A null request is answered a little late, as a real meter would.
  always @(posedge clk_i) begin
    if (req_i === 1'b1) begin
      repeat (2) @(posedge clk_i);
      measure(req_ch_i, NULL_RAW);
    end
  end
endmodule

/* File: dv/tb_scsc_top.sv */
module tb_scsc_top;
  import scsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [AW-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0, rdata_o, meas_data_i;
  logic meas_valid_i, ext_adv_i, meas_req_o, reading_valid_o, alarm_clr_o;
  logic [CW-1:0] meas_ch_i, meas_ch_o, reading_ch_o, alarm_ch_o;
  logic [NCH-1:0] relay_o;
  logic [63:0] reading_o;
  logic [23:0] disp_label_o;
  logic ext_trig_i = 1'b0, meter_inst_i = 1'b0;
  int mismatches = 0, checked = 0;
  scsc_top #(.TICK_N(4)) i_scsc_top (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_trig_i(ext_trig_i), .ext_adv_i(ext_adv_i),
    .meter_inst_i(meter_inst_i),
    .meas_valid_i(meas_valid_i), .meas_ch_i(meas_ch_i),
    .meas_data_i(meas_data_i), .meas_req_o(meas_req_o),
    .meas_ch_o(meas_ch_o), .relay_o(relay_o),
    .reading_valid_o(reading_valid_o), .reading_ch_o(reading_ch_o),
    .reading_o(reading_o), .alarm_clr_o(alarm_clr_o),
    .alarm_ch_o(alarm_ch_o), .disp_label_o(disp_label_o));
  scsc_meter_model i_scsc_meter_model (
    .clk_i(core_clk_i), .req_i(meas_req_o), .req_ch_i(meas_ch_o),
    .adv_o(ext_adv_i), .valid_o(meas_valid_i), .ch_o(meas_ch_i),
    .data_o(meas_data_i));
  always #50 core_clk_i = ~core_clk_i;
  task automatic give_verdict();
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so sample there.
  task automatic rc(input string n, input logic [AW-1:0] a,
                    input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, {32'h0, e}, {32'h0, rdata_o & m});
  endtask
  task automatic wait_rd();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_i);
      #1;
      if (reading_valid_o === 1'b1) return;
    end
    chk("reading_valid_o", 64'h1, 64'h0);
  endtask
  // A hang is cut short well beyond the 175 or so cycles the tests take.
  initial begin
    #500_000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rc("ctrl", A_CTRL, 32'h0000_003F, 32'h0000_000C);
    rc("gain_lo", A_GLO, 32'hFFFF_FFFF, 32'h0000_0001);
    rc("offs_lo", A_OLO, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(A_LIST, 32'h0000_0003);
    wr(A_CTRL, 32'h0000_0001);
    rc("ctrl", A_CTRL, 32'h0000_000F, 32'h0000_0005);
    rc("stat", A_STAT, 32'h0000_0001, 32'h0000_0001);
    wr(A_STAT, 32'h0000_000F);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CMD, 32'h0000_0001 << C_INIT);
    i_scsc_meter_model.advance();
    chk("relay_o", 64'h0, {44'h0, relay_o});
    wr(A_CMD, 32'h0000_0001 << C_TRIG);
    repeat (4) @(posedge core_clk_i);
    chk("relay_o", 64'h1, {44'h0, relay_o});
    i_scsc_meter_model.advance();
    chk("relay_o", 64'h2, {44'h0, relay_o});
    wr(A_SEL, 32'h0000_0000);
    wr(A_GLO, 32'h0000_0003);
    wr(A_GHI, 32'h0000_0000);
    wr(A_OLO, 32'h0000_0005);
    wr(A_OHI, 32'h0000_0000);
    wr(A_SEN, 32'h0000_0001);
    fork
      i_scsc_meter_model.measure(5'h00, 32'h0000_000A);
      wait_rd();
    join
    chk("reading_o", 64'h19, reading_o);
    chk("reading_ch_o", 64'h0, {59'h0, reading_ch_o});
    wr(A_CMD, 32'h0000_0001 << C_NULL);
    repeat (12) @(posedge core_clk_i);
    rc("offs_lo", A_OLO, 32'hFFFF_FFFF, 32'h0000_0007);
    wr(A_LIST, 32'h0000_0002);
    rc("scale_en", A_SEN, 32'h0000_0001, 32'h0000_0000);
    wr(A_LIST, 32'h0000_0003);
    rc("scale_en", A_SEN, 32'h0000_0001, 32'h0000_0001);
    rc("gain_lo", A_GLO, 32'hFFFF_FFFF, 32'h0000_0003);
    wr(A_FUNC, 32'h0000_0004);
    rc("scale_en", A_SEN, 32'h0000_0001, 32'h0000_0000);
    rc("gain_lo", A_GLO, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(A_GLO, 32'h0000_0000);
    wr(A_GHI, 32'h0004_0000);
    rc("stat", A_STAT, 32'h0000_0002, 32'h0000_0002);
    // Alarm limits already set must fall when scaling is switched on.
    wr(A_ALRM, 32'h0000_0001);
    wr(A_SEN, 32'h0000_0001);
    #1;
    chk("alarm_clr_o", 64'h1, {63'h0, alarm_clr_o});
    chk("alarm_ch_o", 64'h0, {59'h0, alarm_ch_o});
    rc("alarm", A_ALRM, 32'h000F_FFFF, 32'h0000_0000);
    wr(A_CMD, 32'h0000_0001 << C_CARD);
    rc("scale_en", A_SEN, 32'h0000_0001, 32'h0000_0001);
    // A leading hash reads back as a blank and shows as a degree sign.
    wr(A_LBL, 32'h0023_4300);
    rc("label", A_LBL, 32'h00FF_FFFF, 32'h0020_4300);
    chk("disp_label_o", 64'h00B0_4300, {40'h0, disp_label_o});
    wr(A_LBL, 32'h0031_4141);
    rc("stat", A_STAT, 32'h0000_0004, 32'h0000_0004);
    // Only the lower-bank channel of a pair is put in the list.
    wr(A_FWIRE, 32'h0000_0004);
    wr(A_LIST, 32'h0000_0004);
    rc("fwire", A_FWIRE, 32'h000F_FFFF, 32'h0000_0004);
    wr(A_CMD, 32'h0000_0001 << C_INIT);
    wr(A_CMD, 32'h0000_0001 << C_TRIG);
    #1;
    chk("relay_o", 64'h0000_1004, {44'h0, relay_o});
    wr(A_LIST, 32'h0000_0000);
    wr(A_DIR, 32'h0000_0302);
    #1;
    chk("relay_o", 64'h0000_0004, {44'h0, relay_o});
    wr(A_LIST, 32'h0000_0004);
    meter_inst_i <= 1'b1;
    wr(A_CTRL, 32'h0000_0010);
    rc("ctrl", A_CTRL, 32'h0000_003F, 32'h0000_003C);
    rc("list", A_LIST, 32'h000F_FFFF, 32'h0000_0000);
    wr(A_FWIRE, 32'h0000_0004);
    rc("stat", A_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(A_CTRL, 32'h0000_0011);
    rc("ctrl", A_CTRL, 32'h0000_0003, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0018);
    rc("ctrl", A_CTRL, 32'h0000_000F, 32'h0000_0004);
    // Meter off again, then a scan paced by the external trigger pin.
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0009);
    wr(A_LIST, 32'h0000_0001);
    wr(A_CMD, 32'h0000_0001 << C_INIT);
    ext_trig_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk("relay_o", 64'h1, {44'h0, relay_o});
    wr(A_CMD, 32'h0000_0001 << C_ADV);
    #1;
    chk("relay_o", 64'h0, {44'h0, relay_o});
    wr(A_FUNC, 32'h0000_0002);
    wr(A_SEN, 32'h0000_0001);
    rc("scale_en", A_SEN, 32'h0000_0001, 32'h0000_0000);
    give_verdict();
  end
endmodule
